// File: shared/amr_pkg.sv
// Constants, field layouts and carrier types of the automatic message responder.
// Assumes a 32-bit AXI4-Lite register port and a message decoder on the same clock.
//
// Function
// - Entry matches only its enumeration or logical source
// - Type filter all-types value accepts every type
// - Code filter all-messages value accepts every code
// - Matching message gets the entry's response code
// - Entry counter decrements on each forced response
// - Expired counter gives PACK if valid, else NACK
// - Counter zero at setup means no countdown
// - At most fifteen filter and response entries
// - Dynamic mode: hardware generates the response slot
// - Static mode: response comes from scripted traffic
// - Enabled engine answers all; unmatched get default
// - NORE entry on manager address hides own messages
// - Manager logical address is all-ones byte
// - Type encoding: core type zero, presence code one
package amr_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned AMR_MAX_ENTRIES = 15;
  localparam int unsigned AMR_EA_W        = 48;
  localparam int unsigned AMR_CNT_W       = 16;

  // ---------------------------------------------------------------
  // Bus encodings
  // ---------------------------------------------------------------
  localparam logic [7:0]  AMR_ANY_TYPE    = 8'hff;
  localparam logic [7:0]  AMR_ANY_CODE    = 8'hff;
  localparam logic [7:0]  AMR_MGR_LA      = 8'hff;
  localparam logic [7:0]  AMR_TYPE_CORE   = 8'h00;
  localparam logic [7:0]  AMR_CODE_PRES   = 8'h01;
  localparam logic [3:0]  AMR_RESP_PACK   = 4'ha;
  localparam logic [3:0]  AMR_RESP_NACK   = 4'hf;
  localparam logic [3:0]  AMR_RESP_NORE   = 4'h0;

  // ---------------------------------------------------------------
  // Register map, word aligned byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] AMR_REG_CTRL    = 12'h000;  // [0] dynamic mode
  localparam logic [11:0] AMR_REG_STAT    = 12'h004;  // [7:0] replies, [23:8] hit mask
  localparam logic [11:0] AMR_REG_ENT_BASE= 12'h100;  // 8 words per entry
  localparam int unsigned AMR_ENT_SHIFT   = 5;
  // Word index within an entry
  localparam logic [2:0]  AMR_W_ADDR_LO   = 3'h0;     // source address [31:0]
  localparam logic [2:0]  AMR_W_ADDR_HI   = 3'h1;     // [15:0] addr hi, [16] is_ea
  localparam logic [2:0]  AMR_W_FILT      = 3'h2;     // [7:0] type, [15:8] code
  localparam logic [2:0]  AMR_W_RESP      = 3'h3;     // [3:0] response, [31] enable
  localparam logic [2:0]  AMR_W_CNT       = 3'h4;     // write loads, read live count
  localparam int unsigned AMR_F_IS_EA     = 16;
  localparam int unsigned AMR_F_CODE_LSB  = 8;
  localparam int unsigned AMR_F_EN        = 31;
  localparam logic [1:0]  AMR_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  AMR_RESP_SLVERR = 2'b10;
  localparam logic [31:0] AMR_CTRL_RST    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                src_is_ea;
    logic [AMR_EA_W-1:0] src_addr;
    logic [7:0]          mtype;
    logic [7:0]          mcode;
    logic                crc_ok;
  } amr_msg_s;

  typedef struct packed {
    logic                en;
    logic                is_ea;
    logic [AMR_EA_W-1:0] addr;
    logic [7:0]          type_filter;
    logic [7:0]          code_filter;
    logic [3:0]          resp;
    logic [AMR_CNT_W-1:0] cnt_init;
  } amr_entry_cfg_s;

endpackage : amr_pkg

// File: logic/amr_entry.sv
// One auto_reply_entry: filter match and its response countdown.
// Assumes configuration is stable while a message is presented.
module amr_entry
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Configuration
  input  wire amr_pkg::amr_entry_cfg_s cfg_i,
  input  wire logic                 load_i,
  // Message
  input  wire amr_pkg::amr_msg_s    msg_i,
  input  wire logic                 consume_i,
  // Result
  output logic                      match_o,
  output logic                      armed_o,
  output logic [AMR_CNT_W-1:0]      count_o
);
  import amr_pkg::*;

  logic [AMR_CNT_W-1:0] cnt_r;
  logic                 cnt_on_r;
  wire logic addr_hit = cfg_i.is_ea ? (msg_i.src_is_ea && msg_i.src_addr == cfg_i.addr)
                                    : (!msg_i.src_is_ea
                                       && msg_i.src_addr[7:0] == cfg_i.addr[7:0]);
  wire logic type_hit = (cfg_i.type_filter == AMR_ANY_TYPE)
                        || (cfg_i.type_filter == msg_i.mtype);
  wire logic code_hit = (cfg_i.code_filter == AMR_ANY_CODE)
                        || (cfg_i.code_filter == msg_i.mcode);

  assign match_o = cfg_i.en && addr_hit && type_hit && code_hit;
  // Zero at setup leaves the countdown off until the counter is loaded again
  assign armed_o = !cnt_on_r || (cnt_r != '0);
  assign count_o = cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r    <= '0;
      cnt_on_r <= 1'b0;
    end else if (load_i) begin
      cnt_r    <= cfg_i.cnt_init;
      cnt_on_r <= (cfg_i.cnt_init != '0);
    end else if (consume_i && cnt_on_r && cnt_r != '0) begin
      cnt_r    <= cnt_r - 1'b1;
    end
  end

endmodule // amr_entry

// File: logic/amr_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes the register file answers reads combinationally from the word address.
module amr_axil_slave
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Register file side
  output logic             wr_o,
  output logic [11:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [3:0]       wr_strb_o,
  input  wire logic        wr_ok_i,
  output logic [11:0]      rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_ok_i
);
  import amr_pkg::*;

  logic        aw_have_r, w_have_r;
  logic [11:0] aw_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;

  wire logic aw_take = s_axi_awvalid_i && !aw_have_r && !s_axi_bvalid_o;
  wire logic w_take  = s_axi_wvalid_i && !w_have_r && !s_axi_bvalid_o;
  wire logic do_wr   = aw_have_r && w_have_r && !s_axi_bvalid_o;

  assign s_axi_awready_o = !aw_have_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_have_r && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_o      = do_wr;
  assign wr_addr_o = aw_r;
  assign wr_data_o = wd_r;
  assign wr_strb_o = ws_r;
  assign rd_addr_o = s_axi_araddr_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_r      <= 1'b0;
      w_have_r       <= 1'b0;
      aw_r           <= 12'h000;
      wd_r           <= 32'h0000_0000;
      ws_r           <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= AMR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_r      <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wd_r     <= s_axi_wdata_i;
        ws_r     <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_have_r      <= 1'b0;
        w_have_r       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok_i ? AMR_RESP_OKAY : AMR_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= AMR_RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_ok_i ? rd_data_i : 32'h0000_0000;
      s_axi_rresp_o  <= rd_ok_i ? AMR_RESP_OKAY : AMR_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule // amr_axil_slave

// File: logic/amr_responder.sv
// Automatic message response engine: entry table, priority pick, response slot drive.
// Assumes a decoder on clk_i presents each incoming message for one cycle with msg_valid_i.
module amr_responder
  import amr_pkg::*;
#(
  parameter int unsigned N_ENTRIES = AMR_MAX_ENTRIES
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // AXI4-Lite register port
  input  wire logic [11:0]     s_axi_awaddr_i,
  input  wire logic            s_axi_awvalid_i,
  output logic                 s_axi_awready_o,
  input  wire logic [31:0]     s_axi_wdata_i,
  input  wire logic [3:0]      s_axi_wstrb_i,
  input  wire logic            s_axi_wvalid_i,
  output logic                 s_axi_wready_o,
  output logic [1:0]           s_axi_bresp_o,
  output logic                 s_axi_bvalid_o,
  input  wire logic            s_axi_bready_i,
  input  wire logic [11:0]     s_axi_araddr_i,
  input  wire logic            s_axi_arvalid_i,
  output logic                 s_axi_arready_o,
  output logic [31:0]          s_axi_rdata_o,
  output logic [1:0]           s_axi_rresp_o,
  output logic                 s_axi_rvalid_o,
  input  wire logic            s_axi_rready_i,
  // Incoming message
  input  wire logic            msg_valid_i,
  input  wire amr_pkg::amr_msg_s msg_i,
  input  wire logic [3:0]      script_resp_i,
  // Response slot
  output logic                 resp_valid_o,
  output logic [3:0]           resp_code_o,
  output logic                 resp_dynamic_o
);
  import amr_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (N_ENTRIES < 1 || N_ENTRIES > AMR_MAX_ENTRIES) begin : g_bad_n
    $error("N_ENTRIES must lie between 1 and 15");
  end

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  logic        wr;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        wr_ok, rd_ok;

  amr_axil_slave u_bus (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .wr_o            (wr),
    .wr_addr_o       (wr_addr),
    .wr_data_o       (wr_data),
    .wr_strb_o       (wr_strb),
    .wr_ok_i         (wr_ok),
    .rd_addr_o       (rd_addr),
    .rd_data_i       (rd_data),
    .rd_ok_i         (rd_ok)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic       wr_ctrl  = (wr_addr == AMR_REG_CTRL);
  wire logic       wr_in_tb = (wr_addr >= AMR_REG_ENT_BASE) && (wr_addr[1:0] == 2'b00);
  wire logic [11:0] wr_off  = wr_addr - AMR_REG_ENT_BASE;
  wire logic [6:0] wr_idx   = wr_off[11:AMR_ENT_SHIFT];
  wire logic [2:0] wr_word  = wr_off[4:2];
  wire logic       wr_ent   = wr_in_tb && (wr_idx < 7'(N_ENTRIES))
                              && (wr_word <= AMR_W_CNT);
  assign wr_ok = wr_ctrl || wr_ent || (wr_addr == AMR_REG_STAT);

  wire logic       rd_in_tb = (rd_addr >= AMR_REG_ENT_BASE) && (rd_addr[1:0] == 2'b00);
  wire logic [11:0] rd_off  = rd_addr - AMR_REG_ENT_BASE;
  wire logic [6:0] rd_idx   = rd_off[11:AMR_ENT_SHIFT];
  wire logic [2:0] rd_word  = rd_off[4:2];
  wire logic       rd_ent   = rd_in_tb && (rd_idx < 7'(N_ENTRIES))
                              && (rd_word <= AMR_W_CNT);
  assign rd_ok = (rd_addr == AMR_REG_CTRL) || (rd_addr == AMR_REG_STAT) || rd_ent;

  // Byte-lane merge for the addressed word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Control and status
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [7:0]  reply_cnt_r;
  logic [15:0] hit_seen_r;
  wire  logic  dyn_mode = ctrl_r[0];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= AMR_CTRL_RST;
    end else if (wr && wr_ctrl) begin
      ctrl_r <= merge(ctrl_r, wr_data, wr_strb) & 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Entry table
  // ---------------------------------------------------------------
  logic [31:0]          ent_w_r [N_ENTRIES][5];
  amr_entry_cfg_s       cfg     [N_ENTRIES];
  logic [N_ENTRIES-1:0] match, armed, load, consume;
  logic [AMR_CNT_W-1:0] live    [N_ENTRIES];

  for (genvar e = 0; e < N_ENTRIES; e++) begin : g_ent
    assign cfg[e].addr        = {ent_w_r[e][AMR_W_ADDR_HI][15:0], ent_w_r[e][AMR_W_ADDR_LO]};
    assign cfg[e].is_ea       = ent_w_r[e][AMR_W_ADDR_HI][AMR_F_IS_EA];
    assign cfg[e].type_filter = ent_w_r[e][AMR_W_FILT][7:0];
    assign cfg[e].code_filter = ent_w_r[e][AMR_W_FILT][AMR_F_CODE_LSB +: 8];
    assign cfg[e].resp        = ent_w_r[e][AMR_W_RESP][3:0];
    assign cfg[e].en          = ent_w_r[e][AMR_W_RESP][AMR_F_EN];
    // Load takes the word being written, as the stored copy updates on the same edge
    wire logic [31:0] cnt_wr  = merge(ent_w_r[e][AMR_W_CNT], wr_data, wr_strb);
    assign cfg[e].cnt_init    = cnt_wr[AMR_CNT_W-1:0];
    assign load[e] = wr && wr_ent && (wr_idx == 7'(e)) && (wr_word == AMR_W_CNT);

    for (genvar w = 0; w < 5; w++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          ent_w_r[e][w] <= 32'h0000_0000;
        end else if (wr && wr_ent && wr_idx == 7'(e) && wr_word == 3'(w)) begin
          ent_w_r[e][w] <= merge(ent_w_r[e][w], wr_data, wr_strb);
        end
      end
    end

    amr_entry u_ent (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .cfg_i     (cfg[e]),
      .load_i    (load[e]),
      .msg_i     (msg_i),
      .consume_i (consume[e]),
      .match_o   (match[e]),
      .armed_o   (armed[e]),
      .count_o   (live[e])
    );
  end

  // ---------------------------------------------------------------
  // Priority pick
  // ---------------------------------------------------------------
  // Fixed priority keeps the outcome independent of write order
  logic [N_ENTRIES-1:0] first_hit;
  always_comb begin
    first_hit = '0;
    for (int e = N_ENTRIES - 1; e >= 0; e--) begin
      if (match[e]) begin
        first_hit = '0;
        first_hit[e] = 1'b1;
      end
    end
  end

  logic [3:0] hit_resp;
  logic       hit_armed;
  always_comb begin
    hit_resp  = AMR_RESP_NORE;
    hit_armed = 1'b0;
    for (int e = 0; e < N_ENTRIES; e++) begin
      if (first_hit[e]) begin
        hit_resp  = cfg[e].resp;
        hit_armed = armed[e];
      end
    end
  end

  wire logic       any_hit  = |match;
  wire logic [3:0] dflt     = msg_i.crc_ok ? AMR_RESP_PACK : AMR_RESP_NACK;
  // Own manager traffic falls out of a NORE entry on the manager address
  wire logic [3:0] dyn_code = (any_hit && hit_armed) ? hit_resp : dflt;
  wire logic [3:0] out_code = dyn_mode ? dyn_code : script_resp_i;
  // Only the chosen entry counts down, and only in dynamic mode
  assign consume = (msg_valid_i && dyn_mode && hit_armed) ? first_hit : '0;

  // ---------------------------------------------------------------
  // Response slot drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o   <= 1'b0;
      resp_code_o    <= AMR_RESP_NORE;
      resp_dynamic_o <= 1'b0;
    end else begin
      resp_valid_o   <= msg_valid_i;
      resp_dynamic_o <= dyn_mode;
      if (msg_valid_i) begin
        resp_code_o <= out_code;
      end
    end
  end

  wire logic [15:0] hit_set = 16'(first_hit);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reply_cnt_r <= 8'h00;
      hit_seen_r  <= 16'h0000;
    end else begin
      if (msg_valid_i && dyn_mode) begin
        reply_cnt_r <= reply_cnt_r + 8'h01;
      end
      // New hits win over a clear in the same cycle
      if (wr && wr_addr == AMR_REG_STAT) begin
        hit_seen_r <= (hit_seen_r & ~wr_data[23:8]) | (msg_valid_i ? hit_set : 16'h0000);
      end else if (msg_valid_i) begin
        hit_seen_r <= hit_seen_r | hit_set;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [31:0] ent_rd;
  always_comb begin
    ent_rd = 32'h0000_0000;
    for (int e = 0; e < N_ENTRIES; e++) begin
      if (rd_ent && rd_idx == 7'(e)) begin
        ent_rd = (rd_word == AMR_W_CNT) ? 32'(live[e]) : ent_w_r[e][rd_word];
      end
    end
  end

  assign rd_data = (rd_addr == AMR_REG_CTRL) ? ctrl_r :
                   (rd_addr == AMR_REG_STAT) ? {8'h00, hit_seen_r, reply_cnt_r} :
                   ent_rd;

endmodule // amr_responder

// File: tb/amr_responder_sva.sv
// Concurrent checks on the responder's message and register ports.
// Assumes one clock and a synchronous active-low reset; bound onto amr_responder.
module amr_responder_sva #(
  parameter int unsigned N_ENTRIES = 15
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Register port
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  // Message path
  input wire logic        msg_valid_i,
  input wire logic [3:0]  script_resp_i,
  input wire logic        resp_valid_o,
  input wire logic [3:0]  resp_code_o,
  input wire logic        resp_dynamic_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_resp_follow; msg_valid_i |=> resp_valid_o; endproperty
  property p_resp_pulse; !msg_valid_i |=> !resp_valid_o; endproperty
  property p_static; msg_valid_i ##1 !resp_dynamic_o |-> resp_code_o == $past(script_resp_i);
  endproperty
  property p_code_hold; !resp_valid_o |-> $stable(resp_code_o); endproperty
  property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  property p_ar_block; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  property p_w_block; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  property p_r_answer; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty

  a_resp_follow: assert property (p_resp_follow) else $error("no reply after message");
  a_resp_pulse: assert property (p_resp_pulse) else $error("reply without message");
  a_static: assert property (p_static) else $error("static reply not scripted");
  a_code_hold: assert property (p_code_hold) else $error("reply code moved while idle");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_ar_block: assert property (p_ar_block) else $error("address taken during read answer");
  a_w_block: assert property (p_w_block) else $error("write taken during write answer");
  a_r_answer: assert property (p_r_answer) else $error("read answer late");

  c_dyn: cover property (msg_valid_i ##1 resp_dynamic_o);
  c_stat: cover property (msg_valid_i ##1 !resp_dynamic_o);
  c_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10);
endmodule // amr_responder_sva

bind amr_responder amr_responder_sva #(.N_ENTRIES(N_ENTRIES)) amr_responder_sva_inst (
  .clk_i, .rst_n_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .msg_valid_i, .script_resp_i, .resp_valid_o,
  .resp_code_o, .resp_dynamic_o);

// File: tb/amr_msg_source.sv
// Stand-in for the bus devices that send messages to the responder.
// Assumes the responder samples the message on the rising edge of clk_i.
module amr_msg_source
  import amr_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Message out
  output logic      msg_valid_o,
  output amr_pkg::amr_msg_s msg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    msg_valid_o = 1'b0;
    msg_o       = '0;
  end
  // Inverted after use so a stale message never looks like a fresh one
  task automatic send(input amr_msg_s m);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_o       <= m;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_o       <= ~m;
  endtask
endmodule // amr_msg_source

// File: tb/amr_responder_bench.sv
// Self-checking bench for the responder: register bus tasks and message sequences.
// Assumes the responder, its package and the message source model are compiled first.
module amr_responder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import amr_pkg::*;
  localparam logic [47:0] EA = 48'h01c1_0001_0000;
  logic clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, msg_valid_i, resp_valid_o, resp_dynamic_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, script_resp_i, resp_code_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  amr_msg_s    msg_i;
  int          n_fail = 0;
  int          tests_run = 0;
  logic        dyn_exp = 1'b0;

  amr_responder amr_responder_inst (.clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .msg_valid_i, .msg_i, .script_resp_i, .resp_valid_o, .resp_code_o, .resp_dynamic_o);
  amr_msg_source amr_msg_source_inst (.clk_i, .msg_valid_o(msg_valid_i), .msg_o(msg_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r = AMR_RESP_OKAY);
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    chk({30'h0, s_axi_bresp_o}, {30'h0, r});
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    chk(s_axi_rdata_o, e);
    chk({30'h0, s_axi_rresp_o}, {30'h0, r});
    s_axi_rready_i <= 1'b0;
  endtask

  // Configuration goes in before the counter, as the counter load arms the entry
  task automatic set_entry(input int e, input logic ea, input logic [47:0] a,
      input logic [7:0] t, input logic [7:0] c, input logic [3:0] r, input logic [15:0] n);
    logic [11:0] b;
    b = AMR_REG_ENT_BASE + (12'(e) << AMR_ENT_SHIFT);
    axi_wr(b, a[31:0]);
    axi_wr(b + 12'h4, {15'h0, ea, a[47:32]});
    axi_wr(b + 12'h8, {16'h0, c, t});
    axi_wr(b + 12'hc, {1'b1, 27'h0, r});
    axi_wr(b + 12'h10, {16'h0, n});
  endtask

  task automatic msg(input logic ea, input logic [47:0] a, input logic [7:0] t,
      input logic [7:0] c, input logic ok, input logic [3:0] e);
    amr_msg_source_inst.send({ea, a, t, c, ok});
    #1;
    chk({31'h0, resp_valid_o}, 32'h1);
    chk({28'h0, resp_code_o}, {28'h0, e});
    chk({31'h0, resp_dynamic_o}, {31'h0, dyn_exp});
  endtask

  initial begin
    #50000;
    n_fail++;
    stop_test;
  end

  initial begin
    rst_n_i = 1'b0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_awaddr_i = '0;
    s_axi_araddr_i = '0;
    s_axi_wdata_i  = '0;
    s_axi_wstrb_i  = 4'hf;
    script_resp_i  = 4'h5;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(AMR_REG_CTRL, AMR_CTRL_RST, AMR_RESP_OKAY);
    msg(1'b0, 48'h12, 8'h00, 8'h05, 1'b1, 4'h5);
    axi_wr(AMR_REG_CTRL, 32'h1);
    dyn_exp = 1'b1;
    msg(1'b0, 48'h12, 8'h00, 8'h05, 1'b1, AMR_RESP_PACK);
    msg(1'b0, 48'h12, 8'h00, 8'h05, 1'b0, AMR_RESP_NACK);
    set_entry(0, 1'b0, {40'h0, AMR_MGR_LA}, AMR_ANY_TYPE, AMR_ANY_CODE, AMR_RESP_NORE, 16'h0);
    repeat (3) msg(1'b0, {40'h0, AMR_MGR_LA}, 8'h11, 8'h22, 1'b1, AMR_RESP_NORE);
    msg(1'b0, 48'h13, 8'h11, 8'h22, 1'b1, AMR_RESP_PACK);
    set_entry(1, 1'b1, EA, AMR_TYPE_CORE, AMR_CODE_PRES, AMR_RESP_NACK, 16'h2);
    set_entry(2, 1'b1, EA, AMR_ANY_TYPE, AMR_ANY_CODE, 4'h3, 16'h4);
    msg(1'b1, EA, AMR_TYPE_CORE, AMR_CODE_PRES, 1'b1, AMR_RESP_NACK);
    rd_chk(12'h130, 32'h1, AMR_RESP_OKAY);
    rd_chk(12'h150, 32'h4, AMR_RESP_OKAY);
    msg(1'b1, EA, AMR_TYPE_CORE, 8'h02, 1'b1, 4'h3);
    msg(1'b1, EA, 8'h01, AMR_CODE_PRES, 1'b1, 4'h3);
    msg(1'b1, EA, AMR_TYPE_CORE, AMR_CODE_PRES, 1'b1, AMR_RESP_NACK);
    msg(1'b1, EA, AMR_TYPE_CORE, AMR_CODE_PRES, 1'b1, AMR_RESP_PACK);
    msg(1'b0, EA, AMR_TYPE_CORE, AMR_CODE_PRES, 1'b1, AMR_RESP_PACK);
    rd_chk(12'h150, 32'h2, AMR_RESP_OKAY);
    set_entry(14, 1'b0, 48'h77, AMR_ANY_TYPE, AMR_ANY_CODE, 4'h6, 16'h0);
    msg(1'b0, 48'h77, 8'h00, 8'h09, 1'b0, 4'h6);
    rd_chk(AMR_REG_STAT, 32'h0040_070d, AMR_RESP_OKAY);
    axi_wr(AMR_REG_STAT, 32'h0000_ff00);
    rd_chk(AMR_REG_STAT, 32'h0040_000d, AMR_RESP_OKAY);
    axi_wr(12'hffc, 32'h1, AMR_RESP_SLVERR);
    rd_chk(12'hffc, 32'h0, AMR_RESP_SLVERR);
    stop_test;
  end
endmodule // amr_responder_bench
